// >>> shared/tmrie_pkg.sv
// Package with the register map, field positions and carriers of the timer event-request block.
package tmrie_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] ENABLE_OFF = 8'h0C;
   localparam logic [7:0] FLAGS_OFF = 8'h10;
   localparam logic [7:0] EVGEN_OFF = 8'h14;
   // Reset values of the software registers.
   localparam logic [15:0] ENABLE_RST = 16'h0000;
   localparam logic [15:0] FLAGS_RST = 16'h0000;
   localparam logic [1:0] CTRL_RST = 2'h0;
   // Enable register field positions.
   localparam int UPD_IRQ_BIT = 0;
   localparam int CHAN_IRQ_LSB = 1;
   localparam int TRG_IRQ_BIT = 6;
   localparam int UPD_DMA_BIT = 8;
   localparam int CHAN_DMA_LSB = 9;
   localparam int TRG_DMA_BIT = 14;
   // Writable bits of the enable register; reserved bits stay zero.
   localparam logic [15:0] ENABLE_MASK = 16'h5F5F;
   // Flag register field positions.
   localparam int UPD_FLAG_BIT = 0;
   localparam int CHAN_FLAG_LSB = 1;
   // Control register field positions.
   localparam int UPD_DIS_BIT = 0;
   localparam int UPD_SRC_BIT = 1;
   // Event-generate register field position.
   localparam int UPD_GEN_BIT = 0;
   // Number of capture/compare channels.
   localparam int NUM_CHAN = 4;
   // Events arriving from the timer core, one-cycle pulses except the levels trigger_flag, chan_is_input and count_down.
   typedef struct packed {
      logic rep_overflow;
      logic trigger_reinit;
      logic trigger_event;
      logic trigger_flag;
      logic [NUM_CHAN-1:0] chan_match;
      logic [NUM_CHAN-1:0] chan_capture;
      logic [NUM_CHAN-1:0] chan_is_input;
      logic [NUM_CHAN-1:0] capture_read;
      logic count_down;
   } tmrie_core_evt_s;
   // DMA request pulses towards the DMA controller.
   typedef struct packed {
      logic update;
      logic [NUM_CHAN-1:0] chan;
      logic trigger;
   } tmrie_dma_req_s;
endpackage

// >>> hw/tmrie_event_ctrl.sv
// Interrupt and DMA request logic with enable and flag registers for a general-purpose timer.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
module tmrie_event_ctrl #(
   parameter int CNT_W = 16
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave port.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer core side.
   input wire tmrie_pkg::tmrie_core_evt_s core_evt,
   input wire logic [CNT_W-1:0] auto_reload_value,
   output logic prescaler_clear,
   output logic counter_reinit,
   output logic [CNT_W-1:0] counter_reinit_value,
   output logic update_disable,
   output logic update_source_select,
   // Interrupt controller and DMA controller side.
   output logic irq,
   output tmrie_pkg::tmrie_dma_req_s dma_req
);

   // The counter width must hold the reload value and be sane.
   if (CNT_W < 1 || CNT_W > 32)
   begin : g_bad_width
      $error("CNT_W must lie between 1 and 32.");
   end

   // Software registers.
   logic [15:0] enable_r;
   logic [15:0] flags_r;
   logic [15:0] flags_nxt;
   logic [1:0] ctrl_r;
   // Registered bus answer.
   logic [31:0] prdata_r;
   logic pslverr_r;
   // Registered outputs to the core and DMA controller.
   logic prescaler_clear_r;
   logic counter_reinit_r;
   logic [CNT_W-1:0] counter_reinit_value_r;
   logic irq_r;
   tmrie_pkg::tmrie_dma_req_s dma_req_r;
   // Decoded bus strobes.
   logic setup_phase;
   logic wr_access;
   // Combinational event terms.
   logic gen_update;
   logic update_evt;
   logic [tmrie_pkg::NUM_CHAN-1:0] chan_evt;
   logic [15:0] irq_terms;

   // True when the byte address hits one of the mapped registers.
   function automatic logic addr_mapped(input logic [7:0] a);
      begin
         addr_mapped = (a == tmrie_pkg::CTRL_OFF) || (a == tmrie_pkg::ENABLE_OFF) ||
                       (a == tmrie_pkg::FLAGS_OFF) || (a == tmrie_pkg::EVGEN_OFF);
      end
   endfunction

   // Merges write data into a register honouring the byte strobes of the low half.
   function automatic logic [15:0] strobe_merge(input logic [15:0] old_v,
                                                input logic [31:0] wd,
                                                input logic [3:0] st);
      begin
         strobe_merge = old_v;
         if (st[0])
         begin
            strobe_merge[7:0] = wd[7:0];
         end
         if (st[1])
         begin
            strobe_merge[15:8] = wd[15:8];
         end
      end
   endfunction

   // The setup phase captures the read answer; the access phase completes the transfer.
   assign setup_phase = psel && !penable;
   assign wr_access = psel && penable && pwrite;

   // Every transfer takes exactly one wait-free access phase after setup.
   assign pready = penable;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   // Control bits that steer update generation.
   assign update_disable = ctrl_r[tmrie_pkg::UPD_DIS_BIT];
   assign update_source_select = ctrl_r[tmrie_pkg::UPD_SRC_BIT];

   // Software update generate: a write of one to the generate bit, byte lane zero.
   assign gen_update = wr_access && (paddr == tmrie_pkg::EVGEN_OFF) && pstrb[0] &&
                       pwdata[tmrie_pkg::UPD_GEN_BIT];

   // Update event sources, all suppressed while update generation is disabled.
   always_comb
   begin
      update_evt = 1'b0;
      if (!update_disable)
      begin
         // Repetition counter wrap reloads the counter.
         if (core_evt.rep_overflow)
         begin
            update_evt = 1'b1;
         end
         // Software and trigger reinitialisation count only with source select zero.
         if (!update_source_select && gen_update)
         begin
            update_evt = 1'b1;
         end
         if (!update_source_select && core_evt.trigger_reinit)
         begin
            update_evt = 1'b1;
         end
      end
   end

   // Each channel flags a match in output mode and a capture in input mode.
   always_comb
   begin
      for (int i = 0; i < tmrie_pkg::NUM_CHAN; i++)
      begin
         if (core_evt.chan_is_input[i])
         begin
            chan_evt[i] = core_evt.chan_capture[i];
         end
         else
         begin
            chan_evt[i] = core_evt.chan_match[i];
         end
      end
   end

   // Control register: update disable and update source select.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= tmrie_pkg::CTRL_RST;
      end
      else if (wr_access && (paddr == tmrie_pkg::CTRL_OFF) && pstrb[0])
      begin
         ctrl_r <= pwdata[1:0];
      end
   end

   // Enable register: interrupt and DMA enables, reserved bits held at zero.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enable_r <= tmrie_pkg::ENABLE_RST;
      end
      else if (wr_access && (paddr == tmrie_pkg::ENABLE_OFF))
      begin
         enable_r <= strobe_merge(enable_r, pwdata, pstrb) & tmrie_pkg::ENABLE_MASK;
      end
   end

   // Next flag value: software clears by writing zero, hardware sets win.
   always_comb
   begin
      flags_nxt = flags_r;
      // A zero written on an enabled lane clears; a one leaves the bit alone.
      if (wr_access && (paddr == tmrie_pkg::FLAGS_OFF) && pstrb[0])
      begin
         flags_nxt = flags_r & {8'h00, pwdata[7:0]};
      end
      // Reading a capture register clears that channel's flag too.
      for (int i = 0; i < tmrie_pkg::NUM_CHAN; i++)
      begin
         if (core_evt.capture_read[i])
         begin
            flags_nxt[tmrie_pkg::CHAN_FLAG_LSB+i] = 1'b0;
         end
      end
      // Sets are applied last so an event in the clearing cycle is kept.
      if (update_evt)
      begin
         flags_nxt[tmrie_pkg::UPD_FLAG_BIT] = 1'b1;
      end
      for (int i = 0; i < tmrie_pkg::NUM_CHAN; i++)
      begin
         if (chan_evt[i])
         begin
            flags_nxt[tmrie_pkg::CHAN_FLAG_LSB+i] = 1'b1;
         end
      end
      // Only the update and channel flags live here; the rest read as zero.
      flags_nxt[15:5] = 11'h000;
   end

   // Flag register storage.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags_r <= tmrie_pkg::FLAGS_RST;
      end
      else
      begin
         flags_r <= flags_nxt;
      end
   end

   // Read answer and error are prepared during setup so that data comes from flip-flops.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else if (setup_phase)
      begin
         pslverr_r <= !addr_mapped(paddr);
         prdata_r <= 32'h0000_0000;
         if (!pwrite)
         begin
            // The event-generate register is write-only and reads as zero.
            case (paddr)
               tmrie_pkg::CTRL_OFF: prdata_r <= {30'h0000_0000, ctrl_r};
               tmrie_pkg::ENABLE_OFF: prdata_r <= {16'h0000, enable_r};
               tmrie_pkg::FLAGS_OFF: prdata_r <= {16'h0000, flags_r};
               default: prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Interrupt terms: each flag paired with its enable bit.
   always_comb
   begin
      irq_terms = 16'h0000;
      irq_terms[tmrie_pkg::UPD_IRQ_BIT] = flags_r[tmrie_pkg::UPD_FLAG_BIT] &&
                                         enable_r[tmrie_pkg::UPD_IRQ_BIT];
      for (int i = 0; i < tmrie_pkg::NUM_CHAN; i++)
      begin
         irq_terms[tmrie_pkg::CHAN_IRQ_LSB+i] = flags_r[tmrie_pkg::CHAN_FLAG_LSB+i] &&
                                               enable_r[tmrie_pkg::CHAN_IRQ_LSB+i];
      end
      // The trigger flag is held by the core; it arrives here as a level.
      irq_terms[tmrie_pkg::TRG_IRQ_BIT] = core_evt.trigger_flag &&
                                         enable_r[tmrie_pkg::TRG_IRQ_BIT];
   end

   // Level interrupt, registered so the output is glitch free; costs one cycle of delay.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= |irq_terms;
      end
   end
   assign irq = irq_r;

   // DMA requests: one registered pulse per enabled event.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dma_req_r <= '0;
      end
      else
      begin
         dma_req_r.update <= update_evt && enable_r[tmrie_pkg::UPD_DMA_BIT];
         for (int i = 0; i < tmrie_pkg::NUM_CHAN; i++)
         begin
            dma_req_r.chan[i] <= chan_evt[i] &&
                                 enable_r[tmrie_pkg::CHAN_DMA_LSB+i];
         end
         dma_req_r.trigger <= core_evt.trigger_event &&
                              enable_r[tmrie_pkg::TRG_DMA_BIT];
      end
   end
   assign dma_req = dma_req_r;

   // Software generate reinitialises the counter and clears the prescaler counter, but only while update disable is clear.
   // The prescale factor itself lives in the core and is untouched.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prescaler_clear_r <= 1'b0;
         counter_reinit_r <= 1'b0;
         counter_reinit_value_r <= '0;
      end
      else
      begin
         prescaler_clear_r <= gen_update && !update_disable;
         counter_reinit_r <= gen_update && !update_disable;
         if (gen_update)
         begin
            // Down counting restarts from the reload value, otherwise from zero.
            if (core_evt.count_down)
            begin
               counter_reinit_value_r <= auto_reload_value;
            end
            else
            begin
               counter_reinit_value_r <= '0;
            end
         end
      end
   end
   assign prescaler_clear = prescaler_clear_r;
   assign counter_reinit = counter_reinit_r;
   assign counter_reinit_value = counter_reinit_value_r;

endmodule

// >>> testbench/tmrie_event_ctrl_checker.sv
// Port-level assertions for the timer event-request block.
`timescale 1ns/1ns
module tmrie_event_ctrl_checker #(
   parameter int CNT_W = 16
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Bus writes.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   // Core side.
   input wire tmrie_pkg::tmrie_core_evt_s core_evt,
   input wire logic [CNT_W-1:0] auto_reload_value,
   input wire logic prescaler_clear,
   input wire logic counter_reinit,
   input wire logic [CNT_W-1:0] counter_reinit_value,
   input wire logic update_disable,
   input wire logic update_source_select,
   // Requests.
   input wire logic irq,
   input wire tmrie_pkg::tmrie_dma_req_s dma_req
);
   logic [15:0] en_r; // Enable shadow; byte strobes are honoured as the slave does.
   logic wr_go; // A write completes.
   logic gen_go; // Software asks for an update.
   logic [3:0] ch_ev; // Channel event chosen by direction.
   assign wr_go = psel && penable && pwrite;
   assign gen_go = wr_go && paddr == tmrie_pkg::EVGEN_OFF && pstrb[0] && pwdata[0];
   assign ch_ev = (core_evt.chan_is_input & core_evt.chan_capture)
      | (~core_evt.chan_is_input & core_evt.chan_match);
   // Track the enable register so every gate below uses the design's own view.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         en_r <= tmrie_pkg::ENABLE_RST;
      else if (wr_go && paddr == tmrie_pkg::ENABLE_OFF)
      begin
         // A lane whose strobe is low keeps its old enables.
         if (pstrb[0])
            en_r[7:0] <= pwdata[7:0] & tmrie_pkg::ENABLE_MASK[7:0];
         if (pstrb[1])
            en_r[15:8] <= pwdata[15:8] & tmrie_pkg::ENABLE_MASK[15:8];
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   upd_dma_on_a:
   assert property (!update_disable && en_r[8] && (core_evt.rep_overflow
      || core_evt.trigger_reinit && !update_source_select) |=> dma_req.update)
   else $error("update dma request missing");
   upd_dma_off_a:
   assert property (!en_r[8] |=> !dma_req.update)
   else $error("update dma request while disabled");
   upd_gate_a:
   assert property (update_disable |=> !dma_req.update && !counter_reinit)
   else $error("update while updates are off");
   gen_upd_a:
   assert property (gen_go && !update_disable && !update_source_select
      |=> counter_reinit && prescaler_clear && dma_req.update == $past(en_r[8]))
   else $error("software update lost");
   reinit_val_a:
   assert property (counter_reinit |-> counter_reinit_value
      == ($past(core_evt.count_down) ? $past(auto_reload_value) : '0) ##1 !counter_reinit)
   else $error("wrong reinit value");
   trg_dma_a:
   assert property (core_evt.trigger_event |=> dma_req.trigger == $past(en_r[14]))
   else $error("trigger dma request wrong");
   irq_quiet_a:
   assert property ($past(en_r[4:0]) == 5'h00 && !$past(en_r[6]) |-> !irq)
   else $error("irq with all sources masked");
   irq_upd_a:
   assert property (core_evt.rep_overflow && !update_disable && en_r[0] |-> ##2 irq)
   else $error("update irq missing");
   for (genvar i = 0; i < 4; i++)
   begin : g_ch
      chan_dma_a:
      assert property (ch_ev[i] && en_r[9+i] |=> dma_req.chan[i])
      else $error("channel dma request missing");
   end
   cover property ($rose(irq));
   cover property (counter_reinit);
   cover property (dma_req.trigger);
endmodule

// >>> testbench/tmrie_far_model.sv
// DMA controller model that tallies the DMA requests it receives.
`timescale 1ns/1ns
module tmrie_far_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Requests from the block.
   input wire tmrie_pkg::tmrie_dma_req_s dma_req,
   // Tallies for the bench.
   output int upd_n,
   output int chan_n,
   output int trg_n
);
   // Each pulse is one serviced transfer; a stuck request would inflate the tally.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         upd_n <= 0;
         chan_n <= 0;
         trg_n <= 0;
      end
      else
      begin
         upd_n <= upd_n + int'(dma_req.update);
         chan_n <= chan_n + $countones(dma_req.chan);
         trg_n <= trg_n + int'(dma_req.trigger);
      end
   end
endmodule

// >>> testbench/tb_tmrie_event_ctrl.sv
// Self-checking bench for the timer event-request block.
`timescale 1ns/1ns
module tb_tmrie_event_ctrl;
   localparam logic [7:0] CT = tmrie_pkg::CTRL_OFF;
   localparam logic [7:0] EN = tmrie_pkg::ENABLE_OFF;
   localparam logic [7:0] FL = tmrie_pkg::FLAGS_OFF;
   localparam logic [7:0] EG = tmrie_pkg::EVGEN_OFF;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   tmrie_pkg::tmrie_core_evt_s ev, p; // Core events, and the pulses to fire.
   tmrie_pkg::tmrie_dma_req_s dma_req;
   int upd_n, chan_n, trg_n, miscompares, checks_done;
   tmrie_event_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .core_evt(ev), .auto_reload_value(16'h1234),
      .prescaler_clear(), .counter_reinit(), .counter_reinit_value(), .update_disable(),
      .update_source_select(), .irq(irq), .dma_req(dma_req));
   tmrie_far_model far (.pclk(pclk), .presetn(presetn), .dma_req(dma_req),
      .upd_n(upd_n), .chan_n(chan_n), .trg_n(trg_n));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task chk(input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x)
      begin
         miscompares++;
         $display("FAIL %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One transfer; the wait is bounded so a dead slave ends the run.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'b1)
      begin
         miscompares++;
         final_report();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // Pulse p for one cycle, then give flag and irq time to land.
   task fire;
      ev <= ev | p;
      @(posedge pclk);
      ev <= ev & ~p;
      repeat (2) @(posedge pclk);
   endtask
   task t_regs;
      rd(EN);
      chk(q, 32'h0);
      chk({31'h0, err}, 32'h0);
      wr(EN, 32'hFFFF_FFFF);
      rd(EN);
      chk(q, 32'h0000_5F5F);
      pstrb <= 4'h1;
      wr(EN, 32'h0);
      pstrb <= 4'hF;
      rd(EN);
      chk(q, 32'h0000_5F00);
      rd(EG);
      chk(q, 32'h0);
      rd(8'h20);
      chk({31'h0, err}, 32'h1);
      $display("test regs done");
   endtask
   task t_update;
      wr(EN, 32'h0101);
      p = '0;
      p.rep_overflow = 1'b1;
      fire();
      chk({31'h0, irq}, 32'h1);
      chk(upd_n, 1);
      rd(FL);
      chk(q, 32'h1);
      wr(FL, 32'hFFFF);
      rd(FL);
      chk(q, 32'h1);
      wr(FL, 32'h0);
      rd(FL);
      chk(q, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("test update done");
   endtask
   // Updates blocked by disable and by source select, then allowed.
   task t_gates;
      wr(CT, 32'h1);
      fire();
      wr(EG, 32'h1);
      rd(FL);
      chk(q, 32'h0);
      wr(CT, 32'h2);
      rd(CT);
      chk(q, 32'h2);
      wr(EG, 32'h1);
      p = '0;
      p.trigger_reinit = 1'b1;
      fire();
      rd(FL);
      chk(q, 32'h0);
      wr(CT, 32'h0);
      fire();
      rd(FL);
      chk(q, 32'h1);
      wr(FL, 32'h0);
      ev.count_down <= 1'b1;
      wr(EG, 32'h1);
      rd(FL);
      chk(q, 32'h1);
      chk(upd_n, 3);
      wr(FL, 32'h0);
      $display("test gates done");
   endtask
   // Channels 2 and 4 are inputs and clear by capture read; 1 and 3 clear by writing zero.
   task t_chan;
      wr(EN, 32'h1E1E);
      ev.chan_is_input <= 4'hA;
      @(posedge pclk);
      for (int i = 0; i < 4; i++)
      begin
         p = '0;
         p.chan_match[i] = ~i[0];
         p.chan_capture[i] = i[0];
         fire();
         chk({31'h0, irq}, 32'h1);
         rd(FL);
         chk(q, 32'h1 << (i + 1));
         p = '0;
         p.capture_read[i] = i[0];
         fire();
         if (!i[0])
            wr(FL, 32'h0);
         rd(FL);
         chk(q, 32'h0);
         chk(chan_n, i + 1);
      end
      $display("test chan done");
   endtask
   task t_trig;
      wr(EN, 32'h4040);
      ev.trigger_flag <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      ev.trigger_flag <= 1'b0;
      @(posedge pclk);
      p = '0;
      p.trigger_event = 1'b1;
      fire();
      chk(trg_n, 1);
      wr(EN, 32'h0);
      p.rep_overflow = 1'b1;
      fire();
      chk(trg_n, 1);
      chk(upd_n, 3);
      chk({31'h0, irq}, 32'h0);
      wr(FL, 32'h0);
      $display("test trig done");
   endtask
   // A reset in mid-run must drop the pending flag, the enables and the interrupt.
   task t_reset;
      wr(EN, 32'h0101);
      wr(EG, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rd(EN);
      chk(q, 32'h0);
      rd(FL);
      chk(q, 32'h0);
      $display("test reset done");
   endtask
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      ev = '0;
      miscompares = 0;
      checks_done = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_update();
      t_gates();
      t_chan();
      t_trig();
      t_reset();
      final_report();
   end
endmodule
bind tmrie_event_ctrl tmrie_event_ctrl_checker #(.CNT_W(CNT_W)) chk_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .core_evt(core_evt), .auto_reload_value(auto_reload_value),
   .prescaler_clear(prescaler_clear), .counter_reinit(counter_reinit),
   .counter_reinit_value(counter_reinit_value), .update_disable(update_disable),
   .update_source_select(update_source_select), .irq(irq), .dma_req(dma_req));
